// ==== design/reg_slice_pkg.sv ====
// Purpose: Constants for the auxiliary result, cell sum and overvoltage-clear register slice
// Assumes: 16-bit registers, 12 bits for the cell measure select, on a 32-bit Avalon-MM word bus, one register per aligned word
// Notes: Printed offsets are register indices; byte address is four times the index
package reg_slice_pkg;
    localparam int NUM_CELLS = 12;
    localparam logic [7:0] IDX_CELL_FIRST = 8'h20;
    localparam logic [7:0] IDX_CELL_LAST = 8'h2B;
    localparam logic [7:0] IDX_AUX_ONE = 8'h2D;
    localparam logic [7:0] IDX_AUX_TWO = 8'h2E;
    localparam logic [7:0] IDX_CELL_SUM = 8'h2F;
    localparam logic [7:0] IDX_OV_CLEAR = 8'h40;
    localparam logic [7:0] IDX_MEASURE_SEL = 8'h50;
    localparam int ADDR_W = 10;
    localparam logic [15:0] AUX_MASK = 16'hFFF0;
    localparam logic [15:0] CELL_MASK = 16'hFFFC;
    localparam logic [15:0] OV_CLEAR_MASK = 16'hFFFC;
    localparam logic [15:0] OV_CLEAR_RESET = 16'hFFFC;
    localparam logic [11:0] MEASURE_SEL_RESET = 12'hFFF;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage

// ==== design/cell_sum.sv ====
// Purpose: Registered sum of selected cell results, upper twelve bits of each
// Assumes: Cell results arrive flattened, cell 0 in the low 16 bits
// Notes: One cycle of latency from inputs to sum
`timescale 1ns/1ps
`default_nettype none
module cell_sum #(
    parameter int CELLS = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [16*CELLS-1:0] cell_voltage_result,
    input wire logic [CELLS-1:0] cell_measure_select,
    output logic [15:0] sum
);
    // Sixteen full-scale terms still fit the 16-bit total
    if (CELLS < 1 || CELLS > 16) begin : g_cells_check
        $error("cell_sum: CELLS out of range");
    end

    logic [15:0] term [CELLS];
    logic [15:0] sum_next;

    genvar g;
    generate
        for (g = 0; g < CELLS; g++) begin : g_term
            // Unselected cells add zero
            assign term[g] = cell_measure_select[g] ?
                {4'h0, cell_voltage_result[16*g+4 +: 12]} : 16'h0000;
        end
    endgenerate

    always_comb begin
        sum_next = 16'h0000;
        for (int i = 0; i < CELLS; i++) begin
            sum_next = sum_next + term[i];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sum <= 16'h0000;
        end else begin
            sum <= sum_next;
        end
    end
endmodule // cell_sum
`default_nettype wire

// ==== design/aux_sum_regs.sv ====
// Purpose: Register slice with aux results, cell-voltage total and overvoltage-clear threshold
// Assumes: Avalon-MM slave with waitrequest; one-cycle answer for every access
// Notes: Reads of unmapped indices return zero, writes there are dropped
`timescale 1ns/1ps
`default_nettype none
module aux_sum_regs #(
    parameter int CELLS = reg_slice_pkg::NUM_CELLS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [reg_slice_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [15:0] auxiliary_analog_input_one,
    input wire logic [15:0] auxiliary_analog_input_two,
    input wire logic [16*CELLS-1:0] cell_voltage_result,
    output logic [15:0] overvoltage_clear_threshold,
    output logic [CELLS-1:0] cell_measure_select
);
    // Decode and select register are laid out for exactly twelve cells
    if (CELLS != reg_slice_pkg::NUM_CELLS) begin : g_cells_check
        $error("aux_sum_regs: CELLS must be 12");
    end

    logic [15:0] aux_input_one_result_reg;
    logic [15:0] aux_input_two_result_reg;
    logic [15:0] cell_voltage_sum;
    logic [15:0] ov_clear_reg;
    logic [CELLS-1:0] measure_sel_reg;
    logic served_reg;
    logic [31:0] readdata_next;
    logic [7:0] idx;
    logic word_ok;
    logic req;
    logic accept;

    assign idx = address[9:2];
    assign word_ok = (address[1:0] == 2'b00);
    assign req = read | write;
    // Answer one cycle after the request is seen
    assign accept = req & served_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            served_reg <= 1'b0;
        end else begin
            served_reg <= req & ~served_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~(req & ~served_reg);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aux_input_one_result_reg <= 16'h0000;
            aux_input_two_result_reg <= 16'h0000;
        end else begin
            aux_input_one_result_reg <= auxiliary_analog_input_one & reg_slice_pkg::AUX_MASK;
            aux_input_two_result_reg <= auxiliary_analog_input_two & reg_slice_pkg::AUX_MASK;
        end
    end

    cell_sum #(
        .CELLS(CELLS)
    ) u_sum (
        .clk(clk),
        .rst_n(rst_n),
        .cell_voltage_result(cell_voltage_result),
        .cell_measure_select(measure_sel_reg),
        .sum(cell_voltage_sum)
    );

    // Only writable locations; writes to result indices fall through
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ov_clear_reg <= reg_slice_pkg::OV_CLEAR_RESET;
            measure_sel_reg <= reg_slice_pkg::MEASURE_SEL_RESET;
        end else if (accept && write && word_ok) begin
            if (idx == reg_slice_pkg::IDX_OV_CLEAR) begin
                if (byteenable[0]) ov_clear_reg[7:0] <= writedata[7:0] & reg_slice_pkg::OV_CLEAR_MASK[7:0];
                if (byteenable[1]) ov_clear_reg[15:8] <= writedata[15:8];
            end else if (idx == reg_slice_pkg::IDX_MEASURE_SEL) begin
                if (byteenable[0]) measure_sel_reg[7:0] <= writedata[7:0];
                if (byteenable[1]) measure_sel_reg[CELLS-1:8] <= writedata[CELLS-1:8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overvoltage_clear_threshold <= reg_slice_pkg::OV_CLEAR_RESET;
            cell_measure_select <= reg_slice_pkg::MEASURE_SEL_RESET;
        end else begin
            overvoltage_clear_threshold <= ov_clear_reg;
            cell_measure_select <= measure_sel_reg;
        end
    end

    always_comb begin
        readdata_next = reg_slice_pkg::UNMAPPED_READ;
        if (word_ok) begin
            if (idx >= reg_slice_pkg::IDX_CELL_FIRST && idx <= reg_slice_pkg::IDX_CELL_LAST) begin
                readdata_next = {16'h0000, cell_voltage_result[16*(idx-reg_slice_pkg::IDX_CELL_FIRST) +: 16]
                    & reg_slice_pkg::CELL_MASK};
            end else begin
                case (idx)
                    reg_slice_pkg::IDX_AUX_ONE: readdata_next = {16'h0000, aux_input_one_result_reg};
                    reg_slice_pkg::IDX_AUX_TWO: readdata_next = {16'h0000, aux_input_two_result_reg};
                    reg_slice_pkg::IDX_CELL_SUM: readdata_next = {16'h0000, cell_voltage_sum};
                    reg_slice_pkg::IDX_OV_CLEAR: readdata_next = {16'h0000, ov_clear_reg};
                    reg_slice_pkg::IDX_MEASURE_SEL: readdata_next = {20'h00000, measure_sel_reg};
                    default: readdata_next = reg_slice_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readdata <= 32'h00000000;
        end else if (read && !served_reg) begin
            readdata <= readdata_next;
        end
    end

    // Reference sum built cell by cell, apart from the adder in cell_sum
    logic [15:0] ref_sum;
    always_comb begin
        ref_sum = 16'h0000;
        for (int i = 0; i < CELLS; i++) begin
            if (measure_sel_reg[i]) begin
                ref_sum = ref_sum + {4'h0, cell_voltage_result[16*i+4 +: 12]};
            end
        end
    end

    // A write that lands at this edge on the given index
    sequence write_taken_s(logic [7:0] which);
        accept && write && word_ok && idx == which;
    endsequence

    // A read seen for the first time at this edge on the given index
    sequence read_issue_s(logic [7:0] which);
        read && !served_reg && word_ok && idx == which;
    endsequence

    sequence request_new_s;
        req && !served_reg;
    endsequence

    // One answer cycle, then waiting again
    sequence answer_s;
        !waitrequest ##1 waitrequest;
    endsequence

    // Checks that look back one cycle wait for a clean edge after reset release
    aux_low_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        aux_input_one_result_reg[3:0] == 4'h0 && aux_input_two_result_reg[3:0] == 4'h0)
        else $error("aux result low nibble not zero");

    aux_one_track_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |->
        aux_input_one_result_reg == ($past(auxiliary_analog_input_one) & reg_slice_pkg::AUX_MASK))
        else $error("aux one result wrong");

    aux_two_track_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |->
        aux_input_two_result_reg == ($past(auxiliary_analog_input_two) & reg_slice_pkg::AUX_MASK))
        else $error("aux two result wrong");

    aux_one_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        read_issue_s(reg_slice_pkg::IDX_AUX_ONE) |=> readdata == {16'h0000, $past(aux_input_one_result_reg)})
        else $error("aux one read wrong");

    aux_two_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        read_issue_s(reg_slice_pkg::IDX_AUX_TWO) |=> readdata == {16'h0000, $past(aux_input_two_result_reg)})
        else $error("aux two read wrong");

    sum_value_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> cell_voltage_sum == $past(ref_sum))
        else $error("cell sum mismatch");

    sum_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        read_issue_s(reg_slice_pkg::IDX_CELL_SUM) |=> readdata == {16'h0000, $past(cell_voltage_sum)})
        else $error("cell sum read wrong");

    sum_unselected_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $past(measure_sel_reg) == '0 |-> cell_voltage_sum == 16'h0000)
        else $error("empty selection gave nonzero sum");

    sel_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> cell_measure_select == $past(measure_sel_reg))
        else $error("select output lags wrongly");

    ov_low_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        ov_clear_reg[1:0] == 2'b00)
        else $error("threshold low bits set");

    ov_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        write_taken_s(reg_slice_pkg::IDX_OV_CLEAR) ##0 byteenable[1:0] == 2'b11
        |=> ov_clear_reg == ($past(writedata[15:0]) & reg_slice_pkg::OV_CLEAR_MASK))
        else $error("threshold write lost");

    ov_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        read_issue_s(reg_slice_pkg::IDX_OV_CLEAR) |=> readdata == {16'h0000, $past(ov_clear_reg)})
        else $error("threshold read wrong");

    thr_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> overvoltage_clear_threshold == $past(ov_clear_reg))
        else $error("threshold output lags wrongly");

    cell_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        read_issue_s(reg_slice_pkg::IDX_CELL_FIRST)
        |=> readdata[1:0] == 2'b00 && readdata[31:16] == 16'h0000)
        else $error("cell read low bits set");

    ro_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        accept && write && idx != reg_slice_pkg::IDX_OV_CLEAR |=> $stable(ov_clear_reg))
        else $error("threshold changed by other write");

    answer_time_a: assert property (@(posedge clk) disable iff (!rst_n)
        request_new_s |=> answer_s)
        else $error("answer not one cycle later");

    // Bus stays quiet while reset is held
    reset_idle_a: assert property (@(posedge clk)
        !rst_n |=> waitrequest && readdata == 32'h00000000)
        else $error("bus not idle in reset");
endmodule // aux_sum_regs
`default_nettype wire

// ==== test/test_aux_sum_regs.sv ====
// Purpose: Self-checking bench for the aux result, cell sum and threshold register slice
// Assumes: Avalon-MM slave answering after its own wait cycles
// Notes: Reads queue their expected value; a monitor compares when the answer arrives
`timescale 1ns/1ps
`default_nettype none
module test_aux_sum_regs;
    localparam int N = reg_slice_pkg::NUM_CELLS;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [reg_slice_pkg::ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] be = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    logic [15:0] aux_one = 16'h0000;
    logic [15:0] aux_two = 16'h0000;
    logic [16*N-1:0] cells = '0;
    logic [16*N-1:0] nv;
    logic [15:0] ov_thr;
    logic [N-1:0] sel;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h00000033;
    logic [31:0] r;
    logic [15:0] s;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;

    aux_sum_regs #(.CELLS(N)) DUT (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
        .auxiliary_analog_input_one(aux_one), .auxiliary_analog_input_two(aux_two),
        .cell_voltage_result(cells), .overvoltage_clear_threshold(ov_thr), .cell_measure_select(sel));

    always #10 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_compared++;
        if (seen !== expv) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %08h expected %08h", $time, seen, expv);
        end
    endtask

    task automatic close_out();
        $display("counts: %0d compared, %0d failed", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Request held until waitrequest is sampled low, then released for one idle edge
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        bus(idx, 1'b0, 32'h00000000);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (read === 1'b1 && waitrequest === 1'b0) begin
            check(readdata, exp_q.pop_front());
        end
        if (cycles == 4000) begin
            fail_count++;
            close_out();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({16'h0000, ov_thr}, {16'h0000, reg_slice_pkg::OV_CLEAR_RESET});
        check({20'h00000, sel}, {20'h00000, reg_slice_pkg::MEASURE_SEL_RESET});
        rd(reg_slice_pkg::IDX_OV_CLEAR, reg_slice_pkg::OV_CLEAR_RESET);
        $display("test reset_values done");
        for (int i = 0; i < 6; i++) begin
            r = (i == 0) ? 32'hFFFFFFFF : rnd();
            aux_one <= r[15:0];
            aux_two <= r[31:16];
            repeat (2) @(posedge clk);
            rd(reg_slice_pkg::IDX_AUX_ONE, r[15:0] & reg_slice_pkg::AUX_MASK);
            rd(reg_slice_pkg::IDX_AUX_TWO, r[31:16] & reg_slice_pkg::AUX_MASK);
        end
        $display("test aux_results done");
        for (int i = 0; i < 6; i++) begin
            s = 16'h0000;
            r = (i == 0) ? 32'h00000FFF : (i == 1) ? 32'h00000000 : rnd();
            for (int k = 0; k < N; k++) begin
                nv[k*16 +: 16] = (i == 0) ? 16'hFFFF : 16'(rnd());
                if (r[k]) s = s + {4'h0, nv[k*16+4 +: 12]};
            end
            cells <= nv;
            bus(reg_slice_pkg::IDX_MEASURE_SEL, 1'b1, {20'h00000, r[11:0]});
            repeat (3) @(posedge clk);
            check({20'h00000, sel}, {20'h00000, r[11:0]});
            rd(reg_slice_pkg::IDX_MEASURE_SEL, {4'h0, r[11:0]});
            rd(reg_slice_pkg::IDX_CELL_SUM, s);
            rd(8'h20 + i[7:0], nv[i*16 +: 16] & reg_slice_pkg::CELL_MASK);
            rd(8'h2B - i[7:0], nv[(11-i)*16 +: 16] & reg_slice_pkg::CELL_MASK);
        end
        $display("test cell_sum done");
        r = rnd();
        bus(reg_slice_pkg::IDX_AUX_ONE, 1'b1, r);
        bus(reg_slice_pkg::IDX_AUX_TWO, 1'b1, r);
        bus(reg_slice_pkg::IDX_CELL_SUM, 1'b1, r);
        rd(reg_slice_pkg::IDX_AUX_ONE, aux_one & reg_slice_pkg::AUX_MASK);
        rd(reg_slice_pkg::IDX_AUX_TWO, aux_two & reg_slice_pkg::AUX_MASK);
        rd(reg_slice_pkg::IDX_CELL_SUM, s);
        rd(8'h3C, reg_slice_pkg::UNMAPPED_READ[15:0]);
        $display("test readonly_writes done");
        for (int i = 0; i < 5; i++) begin
            r = (i == 0) ? 32'h0000FFFF : (i == 1) ? 32'h00000000 : rnd();
            bus(reg_slice_pkg::IDX_OV_CLEAR, 1'b1, r);
            rd(reg_slice_pkg::IDX_OV_CLEAR, r[15:0] & reg_slice_pkg::OV_CLEAR_MASK);
            check({16'h0000, ov_thr}, {16'h0000, r[15:0] & reg_slice_pkg::OV_CLEAR_MASK});
        end
        // Upper lane only: low byte keeps the last loop value
        be <= 4'h2;
        bus(reg_slice_pkg::IDX_OV_CLEAR, 1'b1, 32'h0000A5A5);
        be <= 4'hF;
        rd(reg_slice_pkg::IDX_OV_CLEAR, {8'hA5, r[7:0] & 8'hFC});
        check({16'h0000, ov_thr}, {16'h0000, 8'hA5, r[7:0] & 8'hFC});
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({16'h0000, ov_thr}, {16'h0000, reg_slice_pkg::OV_CLEAR_RESET});
        check({20'h00000, sel}, {20'h00000, reg_slice_pkg::MEASURE_SEL_RESET});
        rd(reg_slice_pkg::IDX_OV_CLEAR, reg_slice_pkg::OV_CLEAR_RESET);
        rd(reg_slice_pkg::IDX_MEASURE_SEL, {4'h0, reg_slice_pkg::MEASURE_SEL_RESET});
        $display("test threshold done");
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule // test_aux_sum_regs
`default_nettype wire
